// ### core/pattern_gen_map.svh
// Offsets, field positions, reset values and sizes of the pattern generator.
// Assumes one pixel clock domain and a plain byte-wide register port.
`ifndef PATTERN_GEN_MAP_SVH
`define PATTERN_GEN_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PG_CTL_ADDR       8'h64
`define PG_CFG_ADDR       8'h65
`define PG_IND_INDEX_ADDR 8'h66
`define PG_IND_VALUE_ADDR 8'h67
`define PG_STATUS_ADDR    8'h68

// ------------------------------------------------------------
// Config bits and reset values
// ------------------------------------------------------------
`define CFG_ENABLE   0
`define CFG_COLOR18  1
`define CFG_INT_TIME 2
`define CFG_EXT_CLK  3
`define CFG_INVERT   4
`define CFG_SCROLL   5
`define CFG_RESET    8'h00
`define CTL_RESET    8'h01
`define CTL_CHK_CUST 5
`define CTL_VCOM_REV 6

// ------------------------------------------------------------
// Indirect map indices
// ------------------------------------------------------------
`define IND_DEPTH    16
`define IND_RED      4'h0
`define IND_GREEN    4'h1
`define IND_BLUE     4'h2
`define IND_SEQ_CTL  4'h3
`define IND_ORDER0   4'h4
`define IND_HACT_LO  4'hc
`define IND_VACT_LO  4'hd
`define IND_ACT_HI   4'he
`define IND_BLANK    4'hf

// ------------------------------------------------------------
// Patterns
// ------------------------------------------------------------
`define PAT_CUSTOM   5'd14
`define PAT_CHECKER  5'd15
`define PAT_VCOM     5'd16
`define PAT_BARS     5'd17
`define SYNC_DELAY   2

`endif

// ### core/pattern_gen_pkg.sv
// Types shared by the pattern generator and its bench.
// Assumes 8 bits per colour component.
package pattern_gen_pkg;
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } rgb_t;

   typedef struct packed {
      logic de;
      logic hs;
      logic vs;
   } sync_t;
endpackage

// ### core/video_test_pattern_generator.sv
// Video test pattern generator with external or internal frame timing.
// Assumes the pixel clock mclk and synchronous video inputs.
`include "pattern_gen_map.svh"
`timescale 1ns/100ps
`default_nettype none

module video_test_pattern_generator
   import pattern_gen_pkg::*;
#(
   parameter int CW = 12
) (
   input  wire logic   mclk,
   input  wire logic   rst_b,
   input  wire rgb_t   in_rgb,
   input  wire sync_t  in_sync,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic   reg_wr,
   input  wire logic   reg_rd,
   output var  logic [7:0] reg_rdata,
   output var  rgb_t   out_rgb,
   output var  sync_t  out_sync,
   output var  logic   ext_clk_sel
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] grad(input logic [CW-1:0] pos, input logic [CW-1:0] len);
      logic [CW+7:0] q;
      q = '0;
      if (len != '0)
         q = {pos, 8'h00} / {8'h00, len};
      return q[7:0];
   endfunction

   function automatic rgb_t paint(input logic [2:0] en, input logic [7:0] v);
      rgb_t c;
      c.red   = en[2] ? v : 8'h00;
      c.green = en[1] ? v : 8'h00;
      c.blue  = en[0] ? v : 8'h00;
      return c;
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]    cfg_reg;
   logic [7:0]    ctl_reg;
   logic [7:0]    index_reg;
   logic [7:0]    ind_mem [`IND_DEPTH];
   logic [3:0]    seq_pos_reg;
   logic          vblank_reg;
   logic          ind_hit;

   assign ind_hit = (index_reg < 8'(`IND_DEPTH));

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cfg_reg   <= `CFG_RESET;
         ctl_reg   <= `CTL_RESET;
         index_reg <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `PG_CFG_ADDR)
            cfg_reg <= reg_wdata;
         if (reg_addr == `PG_CTL_ADDR)
            ctl_reg <= reg_wdata;
         if (reg_addr == `PG_IND_INDEX_ADDR)
            index_reg <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < `IND_DEPTH; i++)
            ind_mem[i] <= 8'h00;
      end else if (reg_wr && reg_addr == `PG_IND_VALUE_ADDR && ind_hit) begin
         ind_mem[index_reg[3:0]] <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `PG_CFG_ADDR:       reg_rdata <= cfg_reg;
            `PG_CTL_ADDR:       reg_rdata <= ctl_reg;
            `PG_IND_INDEX_ADDR: reg_rdata <= index_reg;
            `PG_IND_VALUE_ADDR: reg_rdata <= ind_hit ? ind_mem[index_reg[3:0]] : 8'h00;
            `PG_STATUS_ADDR:    reg_rdata <= {3'h0, vblank_reg, seq_pos_reg};
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b)
         ext_clk_sel <= 1'b0;
      else
         ext_clk_sel <= cfg_reg[`CFG_INT_TIME] & cfg_reg[`CFG_EXT_CLK];
   end

   // ------------------------------------------------------------
   // Internal timing
   // ------------------------------------------------------------
   logic [CW-1:0] hact;
   logic [CW-1:0] vact;
   logic [CW-1:0] htotal;
   logic [CW-1:0] vtotal;
   logic [CW-1:0] hcnt_reg;
   logic [CW-1:0] vcnt_reg;
   sync_t         int_sync;
   sync_t         src_sync;

   assign hact   = CW'({ind_mem[`IND_ACT_HI][3:0], ind_mem[`IND_HACT_LO]});
   assign vact   = CW'({ind_mem[`IND_ACT_HI][7:4], ind_mem[`IND_VACT_LO]});
   assign htotal = hact + CW'({ind_mem[`IND_BLANK][3:0], 4'h0}) + CW'(16);
   assign vtotal = vact + CW'(ind_mem[`IND_BLANK][7:4]) + CW'(1);

   always_ff @(posedge mclk) begin
      if (!rst_b || !cfg_reg[`CFG_INT_TIME]) begin
         hcnt_reg <= '0;
         vcnt_reg <= '0;
      end else if (hcnt_reg + CW'(1) >= htotal) begin
         hcnt_reg <= '0;
         vcnt_reg <= (vcnt_reg + CW'(1) >= vtotal) ? '0 : vcnt_reg + CW'(1);
      end else begin
         hcnt_reg <= hcnt_reg + CW'(1);
      end
   end

   assign int_sync.de = (hcnt_reg < hact) && (vcnt_reg < vact);
   assign int_sync.hs = (hcnt_reg >= hact);
   assign int_sync.vs = (vcnt_reg >= vact);
   // Syncs from outside are dropped only while enabled with internal timing
   assign src_sync = (cfg_reg[`CFG_ENABLE] && cfg_reg[`CFG_INT_TIME]) ? int_sync : in_sync;

   // ------------------------------------------------------------
   // Stage one and frame measurement
   // ------------------------------------------------------------
   sync_t         sync1_reg;
   rgb_t          rgb1_reg;
   logic [CW-1:0] x_reg;
   logic [CW-1:0] y_reg;
   logic [CW-1:0] width_reg;
   logic [CW-1:0] height_reg;
   logic [CW:0]   low_reg;
   logic          vs_blank_reg;
   logic          frame_start;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sync1_reg <= '0;
         rgb1_reg  <= '0;
      end else begin
         sync1_reg <= src_sync;
         rgb1_reg  <= in_rgb;
      end
   end

   // Frame starts on a VS rise, or on a long DE-low run only when VS stays idle
   assign frame_start = (src_sync.vs && !sync1_reg.vs)
                      || (!src_sync.de && !src_sync.vs && !vs_blank_reg
                          && low_reg == {width_reg, 1'b0} + (CW+1)'(1));

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         low_reg      <= '0;
         vblank_reg   <= 1'b0;
         vs_blank_reg <= 1'b0;
      end else if (src_sync.de) begin
         low_reg      <= '0;
         vblank_reg   <= 1'b0;
         vs_blank_reg <= 1'b0;
      end else begin
         if (src_sync.vs)
            vs_blank_reg <= 1'b1;
         if (low_reg != '1)
            low_reg <= low_reg + (CW+1)'(1);
         if (frame_start || src_sync.vs)
            vblank_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         x_reg     <= '0;
         width_reg <= '0;
      end else if (src_sync.de) begin
         x_reg <= sync1_reg.de ? x_reg + CW'(1) : '0;
      end else if (sync1_reg.de) begin
         width_reg <= x_reg + CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         y_reg      <= '0;
         height_reg <= '0;
      end else if (frame_start) begin
         height_reg <= y_reg;
         y_reg      <= '0;
      end else if (sync1_reg.de && !src_sync.de) begin
         y_reg <= y_reg + CW'(1);
      end
   end

   // ------------------------------------------------------------
   // Auto-scroll sequence
   // ------------------------------------------------------------
   logic [3:0]    dwell_reg;
   logic [7:0]    order_byte;
   logic [3:0]    entry;
   logic [4:0]    pattern_sel;

   always_ff @(posedge mclk) begin
      if (!rst_b || !cfg_reg[`CFG_SCROLL]) begin
         dwell_reg   <= 4'h0;
         seq_pos_reg <= 4'h0;
      end else if (frame_start) begin
         if (dwell_reg >= ind_mem[`IND_SEQ_CTL][7:4]) begin
            dwell_reg   <= 4'h0;
            seq_pos_reg <= (seq_pos_reg >= ind_mem[`IND_SEQ_CTL][3:0])
                           ? 4'h0 : seq_pos_reg + 4'h1;
         end else begin
            dwell_reg <= dwell_reg + 4'h1;
         end
      end
   end

   // Two four-bit entries per byte; entry codes reach pattern 16 at most
   assign order_byte  = ind_mem[4'(`IND_ORDER0) + {1'b0, seq_pos_reg[3:1]}];
   assign entry       = seq_pos_reg[0] ? order_byte[7:4] : order_byte[3:0];
   assign pattern_sel = cfg_reg[`CFG_SCROLL] ? {1'b0, entry} + 5'd1
                                             : ctl_reg[4:0];

   // ------------------------------------------------------------
   // Pattern generation
   // ------------------------------------------------------------
   rgb_t          custom;
   rgb_t          pat;
   rgb_t          pat_fmt;
   logic [7:0]    hg;
   logic [7:0]    vg;
   logic [1:0]    vcom_col;

   assign custom   = {ind_mem[`IND_RED], ind_mem[`IND_GREEN], ind_mem[`IND_BLUE]};
   assign hg       = grad(x_reg, width_reg);
   assign vg       = grad(y_reg, height_reg);
   assign vcom_col = ctl_reg[`CTL_VCOM_REV] ? ~x_reg[1:0] : x_reg[1:0];

   always_comb begin
      pat = '0;
      case (pattern_sel)
         5'd1:  pat = paint(3'b111, 8'hff);
         5'd2:  pat = '0;
         5'd3:  pat = paint(3'b100, 8'hff);
         5'd4:  pat = paint(3'b010, 8'hff);
         5'd5:  pat = paint(3'b001, 8'hff);
         5'd6:  pat = paint(3'b111, hg);
         5'd7:  pat = paint(3'b100, hg);
         5'd8:  pat = paint(3'b010, hg);
         5'd9:  pat = paint(3'b001, hg);
         5'd10: pat = paint(3'b111, vg);
         5'd11: pat = paint(3'b100, vg);
         5'd12: pat = paint(3'b010, vg);
         5'd13: pat = paint(3'b001, vg);
         `PAT_CUSTOM: pat = custom;
         `PAT_CHECKER: begin
            if (x_reg[6] ^ y_reg[6])
               pat = ctl_reg[`CTL_CHK_CUST] ? custom : paint(3'b111, 8'hff);
         end
         `PAT_VCOM: begin
            case (vcom_col)
               2'd0:    pat = paint(3'b110, 8'hff);
               2'd1:    pat = paint(3'b011, 8'hff);
               2'd2:    pat = paint(3'b001, 8'hff);
               default: pat = paint(3'b100, 8'hff);
            endcase
         end
         `PAT_BARS: begin
            case (hg[7:5])
               3'd0:    pat = paint(3'b111, 8'hff);
               3'd1:    pat = paint(3'b110, 8'hff);
               3'd2:    pat = paint(3'b011, 8'hff);
               3'd3:    pat = paint(3'b010, 8'hff);
               3'd4:    pat = paint(3'b101, 8'hff);
               3'd5:    pat = paint(3'b100, 8'hff);
               3'd6:    pat = paint(3'b001, 8'hff);
               default: pat = '0;
            endcase
         end
         default: pat = '0;
      endcase
      pat_fmt = cfg_reg[`CFG_INVERT] ? ~pat : pat;
      if (cfg_reg[`CFG_COLOR18]) begin
         pat_fmt.red[1:0]   = 2'b00;
         pat_fmt.green[1:0] = 2'b00;
         pat_fmt.blue[1:0]  = 2'b00;
      end
   end

   // ------------------------------------------------------------
   // Stage two outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         out_sync <= '0;
         out_rgb  <= '0;
      end else begin
         out_sync <= sync1_reg;
         // While enabled, blanking carries zero pixels so the link sees no stray colour
         if (!cfg_reg[`CFG_ENABLE])
            out_rgb <= rgb1_reg;
         else
            out_rgb <= sync1_reg.de ? pat_fmt : '0;
      end
   end

endmodule // video_test_pattern_generator

`default_nettype wire

// ### tb/pattern_gen_props.sv
// Checker for the pattern generator, watching its ports only.
// Assumes it is bound into the top module and mirrors config writes.
`timescale 1ns/100ps
`default_nettype none
module pattern_gen_props
   import pattern_gen_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire rgb_t       in_rgb,
   input wire sync_t      in_sync,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire rgb_t       out_rgb,
   input wire sync_t      out_sync,
   input wire logic       ext_clk_sel
);
   logic [7:0] cfg_reg;
   logic [7:0] ctl_reg;
   logic [1:0] calm_reg;
   logic       calm;
   logic       white;
   // ----------------
   // Mirrors
   // ----------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cfg_reg <= 8'h00;
         ctl_reg <= 8'h01;
      end else if (reg_wr && reg_addr == 8'h65) begin
         cfg_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h64) begin
         ctl_reg <= reg_wdata;
      end
   end
   // Pipeline lag after a write is excused for three clocks
   always_ff @(posedge mclk) begin
      if (!rst_b || reg_wr) begin
         calm_reg <= 2'h0;
      end else if (calm_reg != 2'h3) begin
         calm_reg <= calm_reg + 2'h1;
      end
   end
   assign calm = calm_reg == 2'h3;
   assign white = calm && cfg_reg[0] && !cfg_reg[5] && ctl_reg[4:0] == 5'd1 && out_sync.de;
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_sync_delay: assert property (
      calm && !cfg_reg[2] |-> out_sync == $past(in_sync, 2))
      else $error("sync not two clocks late");
   chk_video_pass: assert property (
      calm && !cfg_reg[0] |-> out_rgb == $past(in_rgb, 2))
      else $error("disabled video not passed");
   chk_low_bits: assert property (
      calm && cfg_reg[0] && cfg_reg[1] |-> (out_rgb & 24'h030303) == 24'h0)
      else $error("low bits set in 18-bit mode");
   chk_white_full: assert property (
      white && !cfg_reg[1] && !cfg_reg[4] |-> out_rgb == 24'hffffff)
      else $error("white not full 24-bit");
   chk_white_invert: assert property (
      white && cfg_reg[4] |-> out_rgb == 24'h000000)
      else $error("inverted white not black");
   chk_unmapped_read: assert property (
      reg_rd && reg_addr == 8'h70 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   chk_ext_clock: assert property (
      calm |-> ext_clk_sel == (cfg_reg[2] && cfg_reg[3]))
      else $error("clock select wrong");
   cov_scroll: cover property (calm && cfg_reg[0] && cfg_reg[5]);
   cov_internal: cover property (calm && cfg_reg[2] && out_sync.de);
   cov_reduced: cover property (calm && cfg_reg[1] && out_sync.de);
endmodule // pattern_gen_props
bind video_test_pattern_generator pattern_gen_props u_pattern_gen_props (
   .mclk(mclk), .rst_b(rst_b), .in_rgb(in_rgb), .in_sync(in_sync),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .out_rgb(out_rgb), .out_sync(out_sync),
   .ext_clk_sel(ext_clk_sel));
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the pattern generator.
// Assumes the source model feeds the video inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import pattern_gen_pkg::*;
;
   logic       mclk = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       run = 1'b0;
   logic       use_vs = 1'b1;
   logic [7:0] reg_rdata;
   logic [7:0] v;
   logic [3:0] p;
   rgb_t       in_rgb, out_rgb, h1, h2;
   sync_t      in_sync, out_sync;
   logic       ext_clk_sel;
   int         error_cnt = 0;
   int         compares = 0;
   int         n, c;
   video_test_pattern_generator u_video_test_pattern_generator (
      .mclk(mclk), .rst_b(rst_b), .in_rgb(in_rgb), .in_sync(in_sync),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .out_rgb(out_rgb), .out_sync(out_sync),
      .ext_clk_sel(ext_clk_sel));
   video_source_model u_video_source_model (
      .mclk(mclk), .run(run), .use_vs(use_vs), .pix(in_rgb), .sync(in_sync));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      h1 <= in_rgb;
      h2 <= h1;
   end
   // ----------------
   // Helpers
   // ----------------
   task automatic fail(input string m);
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) fail($sformatf("byte %h, want %h", g, e));
   endtask
   task automatic chkpix(input rgb_t g, input rgb_t e);
      compares++;
      if (g !== e) fail($sformatf("pixel %h, want %h", g, e));
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      d = reg_rdata;
      reg_rd = 1'b0;
   endtask
   task automatic ind(input logic [7:0] i, input logic [7:0] d);
      wr(8'h66, i);
      wr(8'h67, d);
   endtask
   task automatic wait_de(input logic l);
      n = 0;
      while (out_sync.de !== l && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (n == 400) begin
         fail("timeout");
         print_verdict();
      end
   endtask
   task automatic pix(input logic [7:0] cfg, input rgb_t e);
      wr(8'h65, cfg);
      repeat (4) @(negedge mclk);
      wait_de(1'b1);
      chkpix(out_rgb, e);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_regs;
      rd(8'h65, v);
      chk8(v, 8'h00);
      rd(8'h70, v);
      chk8(v, 8'h00);
      ind(8'h00, 8'h13);
      wr(8'h66, 8'h00);
      rd(8'h67, v);
      chk8(v, 8'h13);
      ind(8'h20, 8'h77);
      rd(8'h67, v);
      chk8(v, 8'h00);
      $display("regs test done");
   endtask
   task automatic t_pix;
      run <= 1'b1;
      pix(8'h01, 24'hffffff);
      pix(8'h11, 24'h000000);
      ind(8'h01, 8'h37);
      ind(8'h02, 8'h56);
      wr(8'h64, 8'h0e);
      pix(8'h01, 24'h133756);
      pix(8'h03, 24'h103454);
      pix(8'h13, 24'hecc8a8);
      wr(8'h65, 8'h00);
      repeat (4) @(negedge mclk);
      wait_de(1'b1);
      chkpix(out_rgb, h2);
      $display("pixel test done");
   endtask
   task automatic t_int;
      run <= 1'b0;
      ind(8'h0c, 8'h08);
      ind(8'h0d, 8'h01);
      ind(8'h0e, 8'h00);
      ind(8'h0f, 8'h00);
      wr(8'h65, 8'h05);
      wait_de(1'b0);
      wait_de(1'b1);
      for (c = 0; out_sync.de === 1'b1 && c < 99; c++) @(negedge mclk);
      chk8(8'(c), 8'd8);
      for (c = 0; out_sync.de === 1'b0 && c < 99; c++) @(negedge mclk);
      chk8(8'(c), 8'd40);
      wr(8'h65, 8'h0d);
      repeat (3) @(negedge mclk);
      chk8({7'h0, ext_clk_sel}, 8'h01);
      $display("internal test done");
   endtask
   task automatic t_vblank;
      use_vs <= 1'b0;
      run <= 1'b1;
      wr(8'h65, 8'h01);
      repeat (120) @(negedge mclk);
      wait_de(1'b1);
      run <= 1'b0;
      wait_de(1'b0);
      repeat (8) @(negedge mclk);
      rd(8'h68, v);
      chk8(v & 8'h10, 8'h00);
      repeat (14) @(negedge mclk);
      rd(8'h68, v);
      chk8(v & 8'h10, 8'h10);
      $display("blank test done");
   endtask
   task automatic t_scroll;
      use_vs <= 1'b1;
      run <= 1'b1;
      ind(8'h03, 8'h02);
      ind(8'h04, 8'h10);
      ind(8'h05, 8'h02);
      wr(8'h65, 8'h21);
      rd(8'h68, v);
      p = v[3:0];
      for (c = 0; c < 4; c++) begin
         repeat (94) @(negedge mclk);
         rd(8'h68, v);
         p = (p == 4'h2) ? 4'h0 : p + 4'h1;
         chk8(v & 8'h0f, {4'h0, p});
      end
      wr(8'h65, 8'h01);
      rd(8'h68, v);
      chk8(v & 8'h0f, 8'h00);
      $display("scroll test done");
   endtask
   task automatic print_verdict;
      $display("compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      rst_b = 1'b1;
      t_regs();
      t_pix();
      t_int();
      t_vblank();
      t_scroll();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire

// ### tb/video_source_model.sv
// Upstream video source: pixels and DE, HS, VS on the pixel clock.
// Assumes the bench sets run and use_vs; outputs move at falling edges.
`timescale 1ns/100ps
`default_nettype none
module video_source_model
   import pattern_gen_pkg::*;
#(
   parameter int W  = 8,
   parameter int HB = 8,
   parameter int LN = 4,
   parameter int VB = 2
) (
   input  wire logic  mclk,
   input  wire logic  run,
   input  wire logic  use_vs,
   output var  rgb_t  pix,
   output var  sync_t sync
);
   int          x = 0;
   int          y = 0;
   logic [23:0] noise = 24'h5aa5c3;
   logic        live;
   // Data never holds, so a stale pixel cannot match by luck
   always @(negedge mclk) begin
      noise <= noise + 24'h3b1d07;
      if (live) begin
         x <= (x == W + HB - 1) ? 0 : x + 1;
         if (x == W + HB - 1) begin
            y <= (y == LN + VB - 1) ? 0 : y + 1;
         end
      end
   end
   assign live = run || x != 0;
   assign pix = noise;
   assign sync = {live && x < W && y < LN, live && x >= W, live && use_vs && y >= LN};
endmodule // video_source_model
`default_nettype wire
